/* verilog/conv_host.sv */
// Host end: Avalon slave and channel enable sequencer
`timescale 1ns/10ps
`default_nettype none
module conv_host
    import chan_ctrl_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES // Output enable wait
)
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic [3:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic clear_req, // Clear request from user
    chan_link_if.host link // Register link
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SEND = 4'b0001,
        ST_RDWAIT = 4'b0100,
        ST_CFG2 = 4'b0011,
        ST_DATA = 4'b0010,
        ST_SETTLE = 4'b0110,
        ST_OUTPUT_ENABLE_BIT = 4'b0111,
        ST_ZERO = 4'b1101,
        ST_OFF = 4'b0101
    } st_type;

    st_type st_ff, nxt_st;
    logic [31:0] cfg_ff, nxt_cfg, rd_ff, nxt_rd, ard_ff, nxt_ard;
    logic [2:0] cmd_ff, nxt_cmd;
    logic [4:0] cadr_ff, nxt_cadr;
    logic [15:0] cdat_ff, nxt_cdat;
    logic busy_ff, nxt_busy, done_ff, nxt_done, wait_ff, nxt_wait;
    logic wr_ff, nxt_wr, rd_o_ff, nxt_rd_o, clr_ff, nxt_clr;
    logic [4:0] la_ff, nxt_la;
    logic [15:0] ld_ff, nxt_ld;
    logic [31:0] cnt_ff, nxt_cnt;
    logic [1:0] ch;
    logic [8:0] ctl_on;

    // cfg: [8:0] control bits, [31:16] data code; ch from cmd address
    assign ch = cadr_ff[1:0];
    assign ctl_on = cfg_ff[8:0];

    // Bus slave and sequence control
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cfg = cfg_ff;
        nxt_rd = rd_ff;
        nxt_ard = ard_ff;
        nxt_cmd = cmd_ff;
        nxt_cadr = cadr_ff;
        nxt_cdat = cdat_ff;
        nxt_busy = busy_ff;
        nxt_done = done_ff;
        nxt_wait = 1'b1;
        nxt_wr = 1'b0;
        nxt_rd_o = 1'b0;
        nxt_la = la_ff;
        nxt_ld = ld_ff;
        nxt_cnt = cnt_ff;
        nxt_clr = clear_req;
        // One wait cycle, then answer in the following cycle
        if ((avs_read || avs_write) && wait_ff)
        begin
            nxt_wait = 1'b0;
            if (avs_read)
            begin
                unique case (avs_address)
                    AV_CFG: nxt_ard = cfg_ff;
                    AV_STATUS: nxt_ard = {30'h0, done_ff, busy_ff};
                    AV_RDATA: nxt_ard = rd_ff;
                    default: nxt_ard = 32'h0;
                endcase
            end
            else if (avs_address == AV_CFG)
                nxt_cfg = avs_writedata;
            else if (avs_address == AV_CMD && !busy_ff)
            begin
                nxt_cmd = avs_writedata[2:0];
                nxt_cadr = avs_writedata[12:8];
                nxt_cdat = avs_writedata[31:16];
                nxt_busy = 1'b1;
                nxt_done = 1'b0;
                nxt_st = ST_SEND;
            end
        end
        unique case (st_ff)
            ST_IDLE: ;
            ST_SEND:
            begin
                nxt_la = cadr_ff;
                nxt_ld = cdat_ff;
                unique case (cmd_ff)
                    CMD_WRITE:
                    begin
                        nxt_wr = 1'b1;
                        nxt_st = ST_OFF;
                    end
                    CMD_READ:
                    begin
                        nxt_rd_o = 1'b1;
                        nxt_st = ST_RDWAIT;
                    end
                    CMD_RESET:
                    begin
                        nxt_la = {KIND_RST, 2'b00};
                        nxt_wr = 1'b1;
                        nxt_st = ST_OFF;
                    end
                    CMD_ENABLE:
                    begin
                        // Boost block first, once per enable
                        nxt_la = {KIND_BOOST, 2'b00};
                        nxt_ld = cdat_ff;
                        nxt_wr = 1'b1;
                        nxt_st = ST_CFG2;
                    end
                    CMD_DISABLE:
                    begin
                        nxt_la = {KIND_DATA, ch};
                        nxt_ld = cfg_ff[31:16];
                        nxt_wr = 1'b1;
                        nxt_st = ST_ZERO;
                    end
                    default: nxt_st = ST_OFF;
                endcase
            end
            ST_CFG2:
            begin
                nxt_la = {KIND_CTRL, ch};
                nxt_ld = {7'h00, ctl_on} & ~(16'h0001 << OUT_EN_BIT);
                nxt_ld[BOOST_EN_BIT] = 1'b1;
                nxt_ld[AMP_EN_BIT] = 1'b1;
                nxt_wr = 1'b1;
                nxt_st = ST_DATA;
            end
            ST_DATA:
            begin
                nxt_la = {KIND_DATA, ch};
                nxt_ld = cfg_ff[31:16];
                nxt_wr = 1'b1;
                nxt_cnt = 32'h0;
                nxt_st = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                nxt_cnt = cnt_ff + 32'h1;
                if (cnt_ff >= SETTLE_CNT)
                    nxt_st = ST_OUTPUT_ENABLE_BIT;
            end
            ST_OUTPUT_ENABLE_BIT:
            begin
                // Rebuild the control word; ld_ff now holds the data code
                nxt_la = {KIND_CTRL, ch};
                nxt_ld = {7'h00, ctl_on};
                nxt_ld[BOOST_EN_BIT] = 1'b1;
                nxt_ld[AMP_EN_BIT] = 1'b1;
                nxt_ld[OUT_EN_BIT] = 1'b1;
                nxt_wr = 1'b1;
                nxt_st = ST_OFF;
            end
            ST_ZERO:
            begin
                nxt_la = {KIND_CTRL, ch};
                nxt_ld = 16'h0000;
                nxt_wr = 1'b1;
                nxt_st = ST_OFF;
            end
            ST_RDWAIT:
                if (link.rvalid)
                begin
                    nxt_rd = {16'h0000, link.rdata};
                    nxt_st = ST_OFF;
                end
            ST_OFF:
            begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= ST_IDLE;
            cfg_ff <= 32'h0;
            rd_ff <= 32'h0;
            ard_ff <= 32'h0;
            cmd_ff <= 3'h0;
            cadr_ff <= 5'h00;
            cdat_ff <= 16'h0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            wait_ff <= 1'b1;
            wr_ff <= 1'b0;
            rd_o_ff <= 1'b0;
            la_ff <= 5'h00;
            ld_ff <= 16'h0000;
            cnt_ff <= 32'h0;
            clr_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cfg_ff <= nxt_cfg;
            rd_ff <= nxt_rd;
            ard_ff <= nxt_ard;
            cmd_ff <= nxt_cmd;
            cadr_ff <= nxt_cadr;
            cdat_ff <= nxt_cdat;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            wait_ff <= nxt_wait;
            wr_ff <= nxt_wr;
            rd_o_ff <= nxt_rd_o;
            la_ff <= nxt_la;
            ld_ff <= nxt_ld;
            cnt_ff <= nxt_cnt;
            clr_ff <= nxt_clr;
        end
    end

    assign avs_readdata = ard_ff;
    assign avs_waitrequest = wait_ff;
    assign link.wr = wr_ff;
    assign link.rd = rd_o_ff;
    assign link.addr = la_ff;
    assign link.wdata = ld_ff;
    assign link.clear_pin = clr_ff;
endmodule : conv_host
`default_nettype wire

/* verilog/chan_ctrl_pkg.sv */
// Constants shared by the converter control ends
`default_nettype none
package chan_ctrl_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    // Register index on the link: {kind[2:0], channel[1:0]}
    localparam logic [2:0] KIND_DATA = 3'h0;
    localparam logic [2:0] KIND_CTRL = 3'h1;
    localparam logic [2:0] KIND_GAIN = 3'h2;
    localparam logic [2:0] KIND_OFFS = 3'h3;
    localparam logic [2:0] KIND_CLRC = 3'h4;
    localparam logic [2:0] KIND_BOOST = 3'h5;
    localparam logic [2:0] KIND_STAT = 3'h6;
    localparam logic [2:0] KIND_RST = 3'h7;
    // Control register field positions
    localparam int RANGE_LSB = 0;
    localparam int RANGE_W = 3;
    localparam int OVR_BIT = 3;
    localparam int BOOST_EN_BIT = 4;
    localparam int OUT_EN_BIT = 5;
    localparam int RSET_BIT = 6;
    localparam int CLR_EN_BIT = 7;
    localparam int AMP_EN_BIT = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CLR_CODE_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'hFFFF;
    localparam logic [15:0] OFFS_RESET = 16'h8000;
    localparam logic [15:0] BOOST_RESET = 16'h0000;
    localparam logic [15:0] CTRL_MASK = 16'h01FF;
    // Calibration length in cycles
    localparam logic [7:0] CAL_CYCLES = 8'h20;
    // Settling wait before output enable
    localparam int SETTLE_US = 200;
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    // Avalon register byte addresses of the controller
    localparam logic [3:0] AV_CMD = 4'h0;
    localparam logic [3:0] AV_CFG = 4'h4;
    localparam logic [3:0] AV_STATUS = 4'h8;
    localparam logic [3:0] AV_RDATA = 4'hC;
    // Controller commands
    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_ENABLE = 3'h3;
    localparam logic [2:0] CMD_DISABLE = 3'h4;
    localparam logic [2:0] CMD_RESET = 3'h5;
endpackage : chan_ctrl_pkg
`default_nettype wire

/* verilog/chan_link_if.sv */
// Register link between controller and converter
`timescale 1ns/10ps
`default_nettype none
interface chan_link_if;
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic clear_pin;
    modport device (input wr, rd, addr, wdata, clear_pin,
                    output rdata, rvalid);
    modport host (output wr, rd, addr, wdata, clear_pin,
                  input rdata, rvalid);
endinterface : chan_link_if
`default_nettype wire

/* verilog/chan_slice.sv */
// One converter channel: control, data, clear and calibration
`timescale 1ns/10ps
`default_nettype none
module chan_slice
    import chan_ctrl_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic soft_rst, // Software reset pulse
    input wire logic [2:0] wr_kind, // Kind of register written
    input wire logic wr_hit, // Write to this channel
    input wire logic [15:0] wdata, // Written word
    input wire logic clear_pin, // Clear input
    output logic [15:0] ctrl, // Control register
    output logic [15:0] data_reg, // Data code
    output logic [15:0] gain_act, // Gain in use
    output logic [15:0] offs_act, // Offset in use
    output logic [15:0] clr_code, // Clear code
    output logic [15:0] out_code, // Code driven on output
    output logic out_on, // Output stage on
    output logic amp_on, // Internal amps powered
    output logic boost_on, // Boost converter on
    output logic cal_busy // Calibration running
);
    logic [15:0] ctrl_ff, nxt_ctrl, data_ff, nxt_data;
    logic [15:0] gpend_ff, nxt_gpend, opend_ff, nxt_opend;
    logic [15:0] gact_ff, nxt_gact, oact_ff, nxt_oact;
    logic [15:0] clr_ff, nxt_clr;
    logic [7:0] cal_ff, nxt_cal;

    // Next values of register state
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_data = data_ff;
        nxt_gpend = gpend_ff;
        nxt_opend = opend_ff;
        nxt_gact = gact_ff;
        nxt_oact = oact_ff;
        nxt_clr = clr_ff;
        nxt_cal = (cal_ff != 8'h00) ? cal_ff - 8'h01 : 8'h00;
        if (soft_rst)
        begin
            nxt_ctrl = CTRL_RESET;
            nxt_data = 16'h0000;
            nxt_gpend = GAIN_RESET;
            nxt_opend = OFFS_RESET;
            nxt_gact = GAIN_RESET;
            nxt_oact = OFFS_RESET;
            nxt_clr = CLR_CODE_RESET;
            nxt_cal = 8'h00;
        end
        else if (wr_hit)
        begin
            unique case (wr_kind)
                KIND_CTRL: nxt_ctrl = wdata & CTRL_MASK;
                KIND_DATA:
                begin
                    nxt_data = wdata;
                    nxt_gact = gpend_ff;
                    nxt_oact = opend_ff;
                    nxt_cal = CAL_CYCLES;
                end
                KIND_GAIN: nxt_gpend = wdata;
                KIND_OFFS: nxt_opend = wdata;
                KIND_CLRC: nxt_clr = wdata;
                default: ;
            endcase
        end
    end

    // Register stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= CTRL_RESET;
            data_ff <= 16'h0000;
            gpend_ff <= GAIN_RESET;
            opend_ff <= OFFS_RESET;
            gact_ff <= GAIN_RESET;
            oact_ff <= OFFS_RESET;
            clr_ff <= CLR_CODE_RESET;
            cal_ff <= 8'h00;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            data_ff <= nxt_data;
            gpend_ff <= nxt_gpend;
            opend_ff <= nxt_opend;
            gact_ff <= nxt_gact;
            oact_ff <= nxt_oact;
            clr_ff <= nxt_clr;
            cal_ff <= nxt_cal;
        end
    end

    // Output stage controls
    assign ctrl = ctrl_ff;
    assign data_reg = data_ff;
    assign gain_act = gact_ff;
    assign offs_act = oact_ff;
    assign clr_code = clr_ff;
    assign cal_busy = (cal_ff != 8'h00);
    assign amp_on = ctrl_ff[AMP_EN_BIT];
    assign boost_on = ctrl_ff[BOOST_EN_BIT];
    assign out_on = ctrl_ff[OUT_EN_BIT];
    // Clear code only on participating channels
    assign out_code = (clear_pin && ctrl_ff[CLR_EN_BIT]) ? clr_ff
                                                          : data_ff;
endmodule : chan_slice
`default_nettype wire

/* verilog/conv_device.sv */
// Converter end: register decode, channels, readback, analog controls
`timescale 1ns/10ps
`default_nettype none
module conv_device
    import chan_ctrl_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset
    chan_link_if.device link, // Register link
    output logic [4*16-1:0] out_code, // Per-channel output codes
    output logic [3:0] out_on, // Output stage enables
    output logic [3:0] amp_on, // Internal amp power
    output logic [3:0] boost_on, // Boost converter power
    output logic [3:0] rset_ext, // External sense resistor
    output logic [3:0] over_range, // 20 percent span extension
    output logic [4*3-1:0] range_sel, // Range per channel
    output logic [15:0] boost_cfg // Boost freq, clamp and phase
);
    logic soft_rst;
    logic [15:0] boost_ff, nxt_boost, rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic [15:0] ctrl_w [NUM_CH];
    logic [15:0] data_w [NUM_CH];
    logic [15:0] gain_w [NUM_CH];
    logic [15:0] offs_w [NUM_CH];
    logic [15:0] clr_w [NUM_CH];
    logic [15:0] code_w [NUM_CH];
    logic [3:0] on_w, amp_w, bst_w, busy_w;
    logic [4*16-1:0] code_ff;
    logic [3:0] on_ff, amp_ff, bst_ff, rset_ff, ovr_ff;
    logic [11:0] range_ff;
    logic [2:0] kind;
    logic [1:0] ch;

    assign kind = link.addr[4:2];
    assign ch = link.addr[1:0];
    assign soft_rst = link.wr && (kind == KIND_RST);

    // One slice per channel
    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++)
        begin : g_ch
            chan_slice u_slice (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .soft_rst(soft_rst),
                .wr_kind(kind),
                .wr_hit(link.wr && (ch == 2'(i))),
                .wdata(link.wdata),
                .clear_pin(link.clear_pin),
                .ctrl(ctrl_w[i]),
                .data_reg(data_w[i]),
                .gain_act(gain_w[i]),
                .offs_act(offs_w[i]),
                .clr_code(clr_w[i]),
                .out_code(code_w[i]),
                .out_on(on_w[i]),
                .amp_on(amp_w[i]),
                .boost_on(bst_w[i]),
                .cal_busy(busy_w[i])
            );
        end
    endgenerate

    // Boost setup kept across range changes; readback mux
    always_comb
    begin
        nxt_boost = boost_ff;
        if (soft_rst)
            nxt_boost = BOOST_RESET;
        else if (link.wr && kind == KIND_BOOST)
            nxt_boost = link.wdata;
        nxt_rvalid = link.rd;
        nxt_rdata = rdata_ff;
        if (link.rd)
        begin
            unique case (kind)
                KIND_DATA: nxt_rdata = data_w[ch];
                KIND_CTRL: nxt_rdata = ctrl_w[ch];
                KIND_GAIN: nxt_rdata = gain_w[ch];
                KIND_OFFS: nxt_rdata = offs_w[ch];
                KIND_CLRC: nxt_rdata = clr_w[ch];
                KIND_BOOST: nxt_rdata = boost_ff;
                KIND_STAT: nxt_rdata = {12'h000, busy_w};
                KIND_RST: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost_ff <= BOOST_RESET;
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            boost_ff <= nxt_boost;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Register the analog controls so each output is a flop
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_ff <= '0;
            on_ff <= 4'h0;
            amp_ff <= 4'h0;
            bst_ff <= 4'h0;
            rset_ff <= 4'h0;
            ovr_ff <= 4'h0;
            range_ff <= 12'h000;
        end
        else
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                code_ff[k*16 +: 16] <= code_w[k];
                on_ff[k] <= on_w[k];
                amp_ff[k] <= amp_w[k];
                bst_ff[k] <= bst_w[k];
                rset_ff[k] <= ctrl_w[k][RSET_BIT];
                // Over-range reaches only voltage ranges (codes 0..3)
                ovr_ff[k] <= ctrl_w[k][OVR_BIT] & ~ctrl_w[k][2];
                range_ff[k*3 +: 3] <= ctrl_w[k][RANGE_LSB +: RANGE_W];
            end
        end
    end

    assign link.rdata = rdata_ff;
    assign link.rvalid = rvalid_ff;
    assign out_code = code_ff;
    assign out_on = on_ff;
    assign amp_on = amp_ff;
    assign boost_on = bst_ff;
    assign rset_ext = rset_ff;
    assign over_range = ovr_ff;
    assign range_sel = range_ff;
    assign boost_cfg = boost_ff;
endmodule : conv_device
`default_nettype wire

/* test/conv_link_monitor.sv */
// Link and analog control checks beside the converter register link
`timescale 1ns/10ps
`default_nettype none
module conv_link_monitor
    import chan_ctrl_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Async reset
    input wire logic wr, // Link write
    input wire logic rd, // Link read
    input wire logic [4:0] addr, // Link address
    input wire logic [15:0] wdata, // Write word
    input wire logic [15:0] rdata, // Read word
    input wire logic rvalid, // Read answer
    input wire logic [3:0] out_on, // Output enables
    input wire logic [3:0] amp_on, // Amp power
    input wire logic [3:0] boost_on // Boost power
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Read answers come one edge after the request
    property p_rd_answer;
        rd |=> rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rvalid_cause;
        rvalid |-> $past(rd);
    endproperty
    a_rvalid_cause: assert property (p_rvalid_cause)
        else $error("stray read answer");
    property p_ctrl_mask;
        rd && addr[4:2] == KIND_CTRL |=> rdata[15:9] == 7'h00;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask)
        else $error("control readback has unused bits set");
    property p_no_overlap;
        !(wr && rd);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write together");
    // Control writes reach the analog controls two edges later
    property p_out_follows;
        wr && addr[4:2] == KIND_CTRL |-> ##2
            out_on[$past(addr[1:0], 2)] == $past(wdata[OUT_EN_BIT], 2);
    endproperty
    a_out_follows: assert property (p_out_follows)
        else $error("output enable does not follow control");
    property p_amp_follows;
        wr && addr[4:2] == KIND_CTRL |-> ##2
            amp_on[$past(addr[1:0], 2)] == $past(wdata[AMP_EN_BIT], 2);
    endproperty
    a_amp_follows: assert property (p_amp_follows)
        else $error("amp power does not follow control");
    property p_boost_follows;
        wr && addr[4:2] == KIND_CTRL |-> ##2
            boost_on[$past(addr[1:0], 2)] == $past(wdata[BOOST_EN_BIT], 2);
    endproperty
    a_boost_follows: assert property (p_boost_follows)
        else $error("boost power does not follow control");
    property p_reset_off;
        $rose(rst_n) |-> out_on == 4'h0 && amp_on == 4'h0 && boost_on == 4'h0;
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("analog controls on after reset");
endmodule : conv_link_monitor
`default_nettype wire

/* test/dac_channel_enable_control_bench.sv */
// Bench joining host controller and converter across the register link
`timescale 1ns/10ps
`default_nettype none
module dac_channel_enable_control_bench
    import chan_ctrl_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic clear_req = 1'b0;
    logic [63:0] out_code;
    logic [3:0] out_on, amp_on, boost_on, rset_ext, over_range;
    logic [11:0] range_sel;
    logic [15:0] boost_cfg;
    logic [31:0] rd_word;
    int n_fail = 0;
    int n_tests = 0;
    chan_link_if link ();
    always #5 core_clk = ~core_clk;
    conv_host #(.SETTLE_CNT(10)) conv_host_inst (.core_clk(core_clk),
        .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .clear_req(clear_req), .link(link));
    conv_device conv_device_inst (.core_clk(core_clk), .rst_n(rst_n),
        .link(link), .out_code(out_code), .out_on(out_on), .amp_on(amp_on),
        .boost_on(boost_on), .rset_ext(rset_ext), .over_range(over_range),
        .range_sel(range_sel), .boost_cfg(boost_cfg));
    conv_link_monitor conv_link_monitor_inst (.core_clk(core_clk),
        .rst_n(rst_n), .wr(link.wr), .rd(link.rd), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .rvalid(link.rvalid),
        .out_on(out_on), .amp_on(amp_on), .boost_on(boost_on));
    task check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // One Avalon transfer, held until waitrequest is seen low
    task av(input logic wr_op, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr_op;
        avs_read <= !wr_op;
        avs_writedata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 50);
        rd_word = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) n_fail++;
    endtask : av
    // Command, then poll until the controller is idle
    task cmd(input logic [2:0] c, input logic [4:0] a, input logic [15:0] d);
        int n;
        n = 0;
        av(1'b1, AV_CMD, {d, 3'h0, a, 5'h00, c});
        do
        begin
            av(1'b0, AV_STATUS, 32'h0);
            n++;
        end
        while (rd_word[0] !== 1'b0 && n < 2000);
        if (n >= 2000) n_fail++;
    endtask : cmd
    task rd_reg(input logic [4:0] a);
        cmd(CMD_READ, a, 16'h0000);
        av(1'b0, AV_RDATA, 32'h0);
    endtask : rd_reg
    task t_reset;
        rd_reg({KIND_CTRL, 2'h0});
        check(rd_word[15:0], CTRL_RESET);
        rd_reg({KIND_CLRC, 2'h1});
        check(rd_word[15:0], CLR_CODE_RESET);
        av(1'b0, 4'h2, 32'h0);
        check(rd_word, 32'h0);
        check({out_on, amp_on, boost_on}, 12'h000);
        $display("reset test done");
    endtask : t_reset
    task t_enable;
        av(1'b1, AV_CFG, {16'h7FFF, 7'h00, 9'h19A});
        cmd(CMD_ENABLE, {KIND_CTRL, 2'h0}, 16'h0A5C);
        check({out_on[0], amp_on[0], boost_on[0], over_range[0]}, 4'hF);
        check(range_sel[2:0], 3'h2);
        check(out_code[15:0], 16'h7FFF);
        cmd(CMD_WRITE, {KIND_DATA, 2'h2}, 16'h1111);
        rd_reg({KIND_STAT, 2'h0});
        check(rd_word[2], 1'b1);
        repeat (40) @(posedge core_clk);
        rd_reg({KIND_STAT, 2'h0});
        check(rd_word[2], 1'b0);
        $display("enable test done");
    endtask : t_enable
    task t_clear;
        cmd(CMD_WRITE, {KIND_CLRC, 2'h0}, 16'h1234);
        cmd(CMD_WRITE, {KIND_CLRC, 2'h2}, 16'h4321);
        clear_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        check(out_code[15:0], 16'h1234);
        check(out_code[47:32], 16'h1111);
        clear_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(out_code[15:0], 16'h7FFF);
        $display("clear test done");
    endtask : t_clear
    task t_gain;
        cmd(CMD_WRITE, {KIND_GAIN, 2'h3}, 16'h1234);
        cmd(CMD_WRITE, {KIND_OFFS, 2'h3}, 16'h0100);
        rd_reg({KIND_GAIN, 2'h3});
        check(rd_word[15:0], GAIN_RESET);
        cmd(CMD_WRITE, {KIND_DATA, 2'h3}, 16'h2222);
        rd_reg({KIND_GAIN, 2'h3});
        check(rd_word[15:0], 16'h1234);
        rd_reg({KIND_OFFS, 2'h3});
        check(rd_word[15:0], 16'h0100);
        check(out_code[63:48], 16'h2222);
        $display("gain test done");
    endtask : t_gain
    task t_range;
        av(1'b1, AV_CFG, 32'h0);
        cmd(CMD_DISABLE, {KIND_CTRL, 2'h0}, 16'h0000);
        check({out_on[0], amp_on[0], boost_on[0]}, 3'h0);
        check(boost_cfg, 16'h0A5C);
        av(1'b1, AV_CFG, {16'h0000, 7'h00, 9'h15D});
        cmd(CMD_ENABLE, {KIND_CTRL, 2'h1}, 16'h0A5C);
        check({over_range[1], rset_ext[1]}, 2'b01);
        check(range_sel[5:3], 3'h5);
        rd_reg({KIND_CTRL, 2'h1});
        check(rd_word[15:0], 16'h017D);
        cmd(CMD_RESET, {KIND_RST, 2'h0}, 16'h0000);
        check({boost_cfg, out_on, boost_on}, {BOOST_RESET, 8'h00});
        $display("range test done");
    endtask : t_range
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_clear();
        t_gain();
        t_range();
        print_verdict();
    end
    // Watchdog, over fifty times the expected run length
    initial
    begin
        #200000;
        n_fail++;
        print_verdict();
    end
endmodule : dac_channel_enable_control_bench
`default_nettype wire
